// [core_bus_timing_stretch.v]
// Implementation choice: the AXI4-Lite register port.
`include "core_bus_timing_map.vh"

module core_bus_timing_stretch #(
  parameter INT_AW = 8,
  parameter AXI_AW = 12
) (
  // clock and reset
  input wire SYS_CLK,
  input wire RST,
  // hardware configuration strap
  input wire EXT_BUS_CFG,
  // axi4-lite write
  input wire [AXI_AW-1:0] AWADDR,
  input wire [2:0] AWPROT,
  input wire AWVALID,
  output wire AWREADY,
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  output wire WREADY,
  output reg [1:0] BRESP,
  output reg BVALID,
  input wire BREADY,
  // axi4-lite read
  input wire [AXI_AW-1:0] ARADDR,
  input wire [2:0] ARPROT,
  input wire ARVALID,
  output wire ARREADY,
  output reg [31:0] RDATA,
  output reg [1:0] RRESP,
  output reg RVALID,
  input wire RREADY,
  // external bus pins
  input wire [7:0] PORT_ZERO_I,
  output reg [7:0] PORT_ZERO_O,
  output reg PORT_ZERO_OE,
  input wire [7:0] PORT_TWO_I,
  output reg [7:0] PORT_TWO_O,
  output reg PORT_TWO_OE,
  output reg ALE,
  output reg RD_N,
  output reg WR_N
);
  localparam [15:0] INT_SIZE = 16'h1 << INT_AW;
  // byte-lane merge for write strobes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // address lies in the enabled on-chip data range
  function is_int;
    input [15:0] a;
    input [15:0] lim;
    begin
      is_int = (a < lim) && (a < INT_SIZE);
    end
  endfunction

  reg [7:0] mem [0:(1<<INT_AW)-1];
  reg aw_v_q, w_v_q, ext_mode_q, cfg_done_q, pend_q, mv_wr_q, mv_inc_q, mv_sel_q, refused_q, int_q, rd_err, wr_err;
  reg [AXI_AW-1:0] awaddr_q;
  reg [31:0] wdata_q, gpio_q, rd_d;
  reg [3:0] wstrb_q;
  reg [7:0] stretch_q, mv_wdata_q, rdata_q;
  reg [2:0] ctrl_q;
  reg [15:0] dptr0_q, dptr1_q, limit_q, icount_q, mv_addr_q;
  reg [1:0] phase_q;
  wire wr_fire, mv_cmd, mv_refuse, launch, launch_int;
  wire eng_busy, eng_done, eng_ale, eng_rd_n, eng_wr_n, eng_p0_oe, eng_p2_oe;
  wire [31:0] wr_val, cur_val;
  wire [15:0] sel_ptr, tmr_count;
  wire [7:0] eng_rdata, eng_p0_o, eng_p2_o;

  // axi handshakes
  assign AWREADY = !aw_v_q && !BVALID;
  assign WREADY = !w_v_q && !BVALID;
  assign ARREADY = !RVALID;
  assign wr_fire = aw_v_q && w_v_q && !BVALID;

  // register view used for read and for partial writes
  always @* begin
    rd_d = 32'h0;
    rd_err = 1'b0;
    case (ARADDR)
      `OFF_CTRL: rd_d = {29'h0, ctrl_q};
      `OFF_DPTR0: rd_d = {16'h0, dptr0_q};
      `OFF_DPTR1: rd_d = {16'h0, dptr1_q};
      `OFF_MOVE: rd_d = {22'h0, mv_inc_q, mv_wr_q, mv_wdata_q};
      `OFF_STATUS: rd_d = {16'h0, rdata_q, 4'h0, ext_mode_q, int_q, refused_q, pend_q | eng_busy};
      `OFF_LIMIT: rd_d = {16'h0, limit_q};
      `OFF_TIMER: rd_d = {16'h0, tmr_count};
      `OFF_GPIO_OUT: rd_d = gpio_q;
      `OFF_GPIO_IN: rd_d = {16'h0, PORT_TWO_I, PORT_ZERO_I};
      `OFF_ICOUNT: rd_d = {16'h0, icount_q};
      `OFF_STRETCH: rd_d = {24'h0, stretch_q};
      default: rd_err = 1'b1;
    endcase
  end

  always @* begin
    wr_err = 1'b0;
    case (awaddr_q)
      `OFF_CTRL, `OFF_DPTR0, `OFF_DPTR1, `OFF_MOVE, `OFF_STATUS, `OFF_LIMIT, `OFF_TIMER,
      `OFF_GPIO_OUT, `OFF_STRETCH: wr_err = 1'b0;
      default: wr_err = 1'b1;
    endcase
  end

  assign cur_val = (awaddr_q == `OFF_CTRL) ? {29'h0, ctrl_q} :
                   (awaddr_q == `OFF_DPTR0) ? {16'h0, dptr0_q} :
                   (awaddr_q == `OFF_DPTR1) ? {16'h0, dptr1_q} :
                   (awaddr_q == `OFF_LIMIT) ? {16'h0, limit_q} :
                   (awaddr_q == `OFF_TIMER) ? {16'h0, tmr_count} :
                   (awaddr_q == `OFF_GPIO_OUT) ? gpio_q :
                   (awaddr_q == `OFF_STRETCH) ? {24'h0, stretch_q} : 32'h0;
  assign wr_val = merge(cur_val, wdata_q, wstrb_q);

  // move command and its refusal
  assign sel_ptr = ctrl_q[`CTRL_DPTR_SEL] ? dptr1_q : dptr0_q;
  assign mv_cmd = wr_fire && (awaddr_q == `OFF_MOVE);
  assign mv_refuse = mv_cmd && (pend_q || eng_busy || (!ext_mode_q && !is_int(sel_ptr, limit_q)));
  assign launch = pend_q && (phase_q == 2'h0);
  assign launch_int = launch && is_int(mv_addr_q, limit_q);

  always @(posedge SYS_CLK) begin
    if (RST) begin
      aw_v_q <= 1'b0;
      w_v_q <= 1'b0;
      awaddr_q <= {AXI_AW{1'b0}};
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      BVALID <= 1'b0;
      BRESP <= `RESP_OKAY;
      RVALID <= 1'b0;
      RRESP <= `RESP_OKAY;
      RDATA <= 32'h0;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_v_q <= 1'b1;
        awaddr_q <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_v_q <= 1'b1;
        wdata_q <= WDATA;
        wstrb_q <= WSTRB;
      end
      if (wr_fire) begin
        aw_v_q <= 1'b0;
        w_v_q <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= wr_err ? `RESP_SLVERR : `RESP_OKAY;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
      if (ARVALID && ARREADY) begin
        RVALID <= 1'b1;
        RDATA <= rd_d;
        RRESP <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

  // strap capture after reset release, instruction-cycle phase
  always @(posedge SYS_CLK) begin
    if (RST) begin
      ext_mode_q <= 1'b0;
      cfg_done_q <= 1'b0;
      phase_q <= 2'h0;
      icount_q <= 16'h0;
    end else begin
      if (!cfg_done_q) begin
        ext_mode_q <= EXT_BUS_CFG;
        cfg_done_q <= 1'b1;
      end
      phase_q <= phase_q + 2'h1;
      if (phase_q == 2'h3) begin
        icount_q <= icount_q + 16'h1;
      end
    end
  end

  // control registers and move sequencing
  always @(posedge SYS_CLK) begin
    if (RST) begin
      stretch_q <= `STRETCH_RST;
      ctrl_q <= `CTRL_RST;
      dptr0_q <= 16'h0;
      dptr1_q <= 16'h0;
      limit_q <= `LIMIT_RST;
      gpio_q <= 32'h0;
      pend_q <= 1'b0;
      mv_wr_q <= 1'b0;
      mv_inc_q <= 1'b0;
      mv_sel_q <= 1'b0;
      mv_wdata_q <= 8'h0;
      mv_addr_q <= 16'h0;
      rdata_q <= 8'h0;
      refused_q <= 1'b0;
      int_q <= 1'b0;
    end else begin
      if (wr_fire) begin
        case (awaddr_q)
          `OFF_CTRL: ctrl_q <= wr_val[2:0];
          `OFF_DPTR0: dptr0_q <= wr_val[15:0];
          `OFF_DPTR1: dptr1_q <= wr_val[15:0];
          `OFF_LIMIT: limit_q <= wr_val[15:0];
          `OFF_GPIO_OUT: gpio_q <= wr_val;
          `OFF_STRETCH: stretch_q <= wr_val[7:0];
          default: ;
        endcase
      end
      if (mv_cmd && !mv_refuse) begin
        pend_q <= 1'b1;
        mv_wr_q <= wdata_q[`MOVE_WR];
        mv_inc_q <= wdata_q[`MOVE_INC];
        mv_wdata_q <= wdata_q[7:0];
        mv_addr_q <= sel_ptr;
        mv_sel_q <= ctrl_q[`CTRL_DPTR_SEL];
      end
      // a new refusal wins over a write-one clear in the same cycle
      if (mv_refuse) begin
        refused_q <= 1'b1;
      end else if (wr_fire && awaddr_q == `OFF_STATUS && wstrb_q[0] && wdata_q[`ST_REFUSED]) begin
        refused_q <= 1'b0;
      end
      if (launch) begin
        pend_q <= 1'b0;
        int_q <= launch_int;
      end
      if (launch_int) begin
        if (mv_wr_q) begin
          mem[mv_addr_q[INT_AW-1:0]] <= mv_wdata_q;
        end else begin
          rdata_q <= mem[mv_addr_q[INT_AW-1:0]];
        end
      end
      if (eng_done && !mv_wr_q) begin
        rdata_q <= eng_rdata;
      end
      // pointer post-increment wraps at 16 bits as the classic pointer does
      if ((launch_int || eng_done) && mv_inc_q) begin
        if (mv_sel_q) begin
          dptr1_q <= dptr1_q + 16'h1;
        end else begin
          dptr0_q <= dptr0_q + 16'h1;
        end
      end
    end
  end

  ext_move u_move (
    .clk(SYS_CLK),
    .rst(RST),
    .start(launch && !launch_int && ext_mode_q),
    .is_wr(mv_wr_q),
    .addr(mv_addr_q),
    .wdata(mv_wdata_q),
    .md(stretch_q[2:0]),
    .p0_i(PORT_ZERO_I),
    .busy(eng_busy),
    .done(eng_done),
    .rdata_q(eng_rdata),
    .ale(eng_ale),
    .rd_n(eng_rd_n),
    .wr_n(eng_wr_n),
    .p0_o(eng_p0_o),
    .p0_oe(eng_p0_oe),
    .p2_o(eng_p2_o),
    .p2_oe(eng_p2_oe)
  );

  tmr_prescale #(.CW(16)) u_tmr (
    .clk(SYS_CLK),
    .rst(RST),
    .fast(ctrl_q[`CTRL_TMR_FAST]),
    .run(ctrl_q[`CTRL_TMR_RUN]),
    .load(wr_fire && awaddr_q == `OFF_TIMER),
    .load_val(wr_val[15:0]),
    .count_q(tmr_count),
    .tick()
  );

  // pin registers: external bus or general-purpose use
  always @(posedge SYS_CLK) begin
    if (RST) begin
      PORT_ZERO_O <= 8'h0;
      PORT_ZERO_OE <= 1'b0;
      PORT_TWO_O <= 8'h0;
      PORT_TWO_OE <= 1'b0;
      ALE <= 1'b0;
      RD_N <= 1'b1;
      WR_N <= 1'b1;
    end else if (ext_mode_q) begin
      PORT_ZERO_O <= eng_p0_o;
      PORT_ZERO_OE <= eng_p0_oe;
      PORT_TWO_O <= eng_p2_o;
      PORT_TWO_OE <= eng_p2_oe;
      ALE <= eng_ale;
      RD_N <= eng_rd_n;
      WR_N <= eng_wr_n;
    end else begin
      PORT_ZERO_O <= gpio_q[7:0];
      PORT_ZERO_OE <= |gpio_q[23:16];
      PORT_TWO_O <= gpio_q[15:8];
      PORT_TWO_OE <= |gpio_q[31:24];
      ALE <= 1'b0;
      RD_N <= 1'b1;
      WR_N <= 1'b1;
    end
  end
endmodule // core_bus_timing_stretch

// [core_bus_timing_map.vh]
`ifndef CORE_BUS_TIMING_MAP_VH
`define CORE_BUS_TIMING_MAP_VH

// register byte addresses
`define OFF_CTRL 12'h000
`define OFF_DPTR0 12'h004
`define OFF_DPTR1 12'h008
`define OFF_MOVE 12'h00c
`define OFF_STATUS 12'h010
`define OFF_LIMIT 12'h014
`define OFF_TIMER 12'h018
`define OFF_GPIO_OUT 12'h01c
`define OFF_GPIO_IN 12'h020
`define OFF_ICOUNT 12'h024
// stretch register keeps its printed index; byte address is four times it
`define STRETCH_IDX 12'h08e
`define OFF_STRETCH 12'h238

// field positions
`define CTRL_TMR_FAST 0
`define CTRL_DPTR_SEL 1
`define CTRL_TMR_RUN 2
`define MOVE_WR 8
`define MOVE_INC 9
`define ST_BUSY 0
`define ST_REFUSED 1
`define ST_INTERNAL 2
`define ST_EXT_MODE 3

// reset values
`define STRETCH_RST 8'h01
`define CTRL_RST 3'h4
`define LIMIT_RST 16'h0100

// timing counts in system clocks
`define CLK_PER_ICYCLE 4
`define CLK_PER_TICK_CLASSIC 12
`define CLK_PER_TICK_FAST 4
`define ALE_CLKS 2
`define STRB_MIN_CLKS 2

// axi responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// [tmr_prescale.v]
`include "core_bus_timing_map.vh"

module tmr_prescale #(
  parameter CW = 16
) (
  input wire clk,
  input wire rst,
  input wire fast,
  input wire run,
  input wire load,
  input wire [CW-1:0] load_val,
  output reg [CW-1:0] count_q,
  output wire tick
);
  localparam [3:0] LIM_CLASSIC = 4'd`CLK_PER_TICK_CLASSIC - 4'd1;
  localparam [3:0] LIM_FAST = 4'd`CLK_PER_TICK_FAST - 4'd1;

  reg [3:0] pre_q;
  wire [3:0] lim;

  assign lim = fast ? LIM_FAST : LIM_CLASSIC;
  assign tick = run && (pre_q >= lim);

  always @(posedge clk) begin
    if (rst) begin
      pre_q <= 4'h0;
      count_q <= {CW{1'b0}};
    end else begin
      if (!run || tick) begin
        pre_q <= 4'h0;
      end else begin
        pre_q <= pre_q + 4'h1;
      end
      if (load) begin
        count_q <= load_val;
      end else if (tick) begin
        count_q <= count_q + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // tmr_prescale

// [ext_move.v]
`include "core_bus_timing_map.vh"

module ext_move (
  input wire clk,
  input wire rst,
  input wire start,
  input wire is_wr,
  input wire [15:0] addr,
  input wire [7:0] wdata,
  input wire [2:0] md,
  input wire [7:0] p0_i,
  output wire busy,
  output wire done,
  output reg [7:0] rdata_q,
  output wire ale,
  output wire rd_n,
  output wire wr_n,
  output wire [7:0] p0_o,
  output wire p0_oe,
  output wire [7:0] p2_o,
  output wire p2_oe
);
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_ADDR = 4'b0010;
  localparam [3:0] S_STRB = 4'b0100;
  localparam [3:0] S_TAIL = 4'b1000;
  localparam [5:0] ICYC = 6'd`CLK_PER_ICYCLE;
  localparam [5:0] ALE_N = 6'd`ALE_CLKS;
  localparam [5:0] STRB_MIN = 6'd`STRB_MIN_CLKS;

  // strobe width in system clocks
  function [5:0] strb_w;
    input [2:0] m;
    begin
      strb_w = (m == 3'h0) ? STRB_MIN : {1'b0, m, 2'b00};
    end
  endfunction

  // clocks left after address phase and strobe: whole move is (m+2) cycles
  function [5:0] tail_w;
    input [2:0] m;
    begin
      tail_w = ({1'b0, m, 2'b00} + {3'b0, 3'h2} * ICYC) - ICYC - strb_w(m);
    end
  endfunction

  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [5:0] cnt_q;
  reg [5:0] cnt_d;
  reg [2:0] md_q;
  reg wr_q;
  reg [15:0] addr_q;
  reg [7:0] wdata_q;

  always @* begin
    state_d = state_q;
    cnt_d = cnt_q + 6'h1;
    case (state_q)
      S_IDLE: begin
        cnt_d = 6'h0;
        if (start) begin
          state_d = S_ADDR;
        end
      end
      S_ADDR: begin
        if (cnt_q == ICYC - 6'h1) begin
          state_d = S_STRB;
          cnt_d = 6'h0;
        end
      end
      S_STRB: begin
        if (cnt_q == strb_w(md_q) - 6'h1) begin
          state_d = S_TAIL;
          cnt_d = 6'h0;
        end
      end
      S_TAIL: begin
        if (cnt_q == tail_w(md_q) - 6'h1) begin
          state_d = S_IDLE;
          cnt_d = 6'h0;
        end
      end
      default: begin
        state_d = S_IDLE;
        cnt_d = 6'h0;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      state_q <= S_IDLE;
      cnt_q <= 6'h0;
      md_q <= 3'h1;
      wr_q <= 1'b0;
      addr_q <= 16'h0;
      wdata_q <= 8'h0;
      rdata_q <= 8'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      if (state_q == S_IDLE && start) begin
        md_q <= md;
        wr_q <= is_wr;
        addr_q <= addr;
        wdata_q <= wdata;
      end
      // pins lag one clock behind state, so sample on first tail clock
      if (state_q == S_TAIL && cnt_q == 6'h0 && !wr_q) begin
        rdata_q <= p0_i;
      end
    end
  end

  assign busy = (state_q != S_IDLE);
  assign done = (state_q == S_TAIL) && (cnt_q == tail_w(md_q) - 6'h1);
  assign ale = (state_q == S_ADDR) && (cnt_q < ALE_N);
  assign rd_n = !((state_q == S_STRB) && !wr_q);
  assign wr_n = !((state_q == S_STRB) && wr_q);
  assign p0_o = (state_q == S_ADDR) ? addr_q[7:0] : wdata_q;
  assign p0_oe = (state_q == S_ADDR) || (wr_q && (state_q == S_STRB || state_q == S_TAIL));
  assign p2_o = addr_q[15:8];
  assign p2_oe = busy;
endmodule // ext_move

// [core_bus_timing_stretch_checker.sv]
module core_bus_timing_stretch_checker (
  // clock and reset
  input wire SYS_CLK,
  input wire RST,
  // strap
  input wire EXT_BUS_CFG,
  // bus pins
  input wire ALE,
  input wire RD_N,
  input wire WR_N,
  input wire [7:0] PORT_ZERO_O,
  input wire PORT_ZERO_OE,
  input wire PORT_TWO_OE,
  // register bus answers
  input wire BVALID,
  input wire BREADY,
  input wire [1:0] BRESP,
  input wire RVALID,
  input wire RREADY,
  input wire [31:0] RDATA
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [5:0] sw_q;
  // counts clocks of the current strobe
  always @(posedge SYS_CLK) begin
    if (RST || (RD_N && WR_N)) sw_q <= 6'h00;
    else sw_q <= sw_q + 6'h01;
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  ale_pulse_width_a: assert property ($rose(ALE) |=> ALE ##1 !ALE)
    else $error("latch pulse is not two clocks");
  ale_strobe_gap_a: assert property ($fell(ALE) |-> (RD_N && WR_N) [*2] ##1 (!RD_N || !WR_N))
    else $error("strobe does not follow latch pulse by two clocks");
  ale_addr_drive_a: assert property (ALE |-> PORT_ZERO_OE && PORT_TWO_OE && RD_N && WR_N)
    else $error("address not driven during latch pulse");
  read_release_a: assert property (!RD_N |-> !PORT_ZERO_OE && PORT_TWO_OE && WR_N)
    else $error("port zero driven during read strobe");
  write_data_a: assert property (!WR_N && !$past(WR_N) |-> PORT_ZERO_OE && $stable(PORT_ZERO_O))
    else $error("write data unstable in strobe");
  strobe_width_a: assert property ($rose(RD_N && WR_N) |-> sw_q == 6'd2 || (sw_q[1:0] == 2'b00 && sw_q >= 6'd4 && sw_q <= 6'd28))
    else $error("strobe width not a legal value");
  tail_hold_a: assert property ($rose(RD_N && WR_N) |-> PORT_TWO_OE [*2])
    else $error("high address dropped before tail");
  gpio_no_ale_a: assert property (ALE |-> EXT_BUS_CFG)
    else $error("latch pulse in io mode");
  bresp_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  rdata_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped");
endmodule // core_bus_timing_stretch_checker

// [ext_mem_model.sv]
module ext_mem_model (
  // clock
  input wire clk,
  // bus from the device
  input wire ale,
  input wire rd_n,
  input wire wr_n,
  input wire [7:0] p0_o,
  input wire [7:0] p2_o,
  // data back
  output wire [7:0] p0_i
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [7:0] mem [0:65535];
  reg [7:0] lo_q;
  reg [7:0] last_q;
  integer i;
  wire [15:0] addr = {p2_o, lo_q};
  initial begin
    for (i = 0; i < 65536; i = i + 1) mem[i] = i[7:0] ^ i[15:8];
    lo_q = 8'h00;
    last_q = 8'h00;
  end
  always @(posedge clk) begin
    if (ale) lo_q <= p0_o;
    if (!wr_n) mem[addr] <= p0_o;
    if (!rd_n) last_q <= mem[addr];
  end
  // released bus shows the inverse of the last value
  assign p0_i = rd_n ? ~last_q : mem[addr];
endmodule // ext_mem_model

// [core_bus_timing_stretch_tb_top.sv]
`include "core_bus_timing_map.vh"
module core_bus_timing_stretch_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  reg SYS_CLK = 1'b0;
  reg RST = 1'b1;
  reg EXT_BUS_CFG = 1'b1;
  reg [11:0] AWADDR = 12'h000;
  reg [11:0] ARADDR = 12'h000;
  reg [31:0] WDATA = 32'h0;
  reg AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  reg [7:0] PORT_TWO_I = 8'h00;
  wire AWREADY, WREADY, BVALID, ARREADY, RVALID, ALE, RD_N, WR_N, PORT_ZERO_OE, PORT_TWO_OE;
  wire [1:0] BRESP, RRESP;
  wire [31:0] RDATA;
  wire [7:0] PORT_ZERO_I, PORT_ZERO_O, PORT_TWO_O;
  integer n_errors = 0, checked = 0, n_ale = 0, code, f, k;
  reg [5:0] sw_q = 6'h0, last_sw = 6'h0, p2_q = 6'h0, last_p2 = 6'h0;
  reg ale_d = 1'b0;
  reg [31:0] rd, t1;
  reg [1:0] resp;
  reg [15:0] a;
  always #20 SYS_CLK = ~SYS_CLK;
  core_bus_timing_stretch i_core_bus_timing_stretch (.SYS_CLK(SYS_CLK), .RST(RST), .EXT_BUS_CFG(EXT_BUS_CFG),
    .AWADDR(AWADDR), .AWPROT(3'h0), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hf),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
    .ARPROT(3'h0), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .PORT_ZERO_I(PORT_ZERO_I), .PORT_ZERO_O(PORT_ZERO_O), .PORT_ZERO_OE(PORT_ZERO_OE),
    .PORT_TWO_I(PORT_TWO_I), .PORT_TWO_O(PORT_TWO_O), .PORT_TWO_OE(PORT_TWO_OE), .ALE(ALE), .RD_N(RD_N), .WR_N(WR_N));
  ext_mem_model i_ext_mem_model (.clk(SYS_CLK), .ale(ALE), .rd_n(RD_N), .wr_n(WR_N), .p0_o(PORT_ZERO_O),
    .p2_o(PORT_TWO_O), .p0_i(PORT_ZERO_I));
  // pin monitor: strobe width, move span, latch pulses
  always @(posedge SYS_CLK) begin
    ale_d <= ALE;
    if (ALE === 1'b1 && !ale_d) n_ale <= n_ale + 1;
    if (RD_N === 1'b0 || WR_N === 1'b0) sw_q <= sw_q + 6'h1;
    else if (sw_q != 6'h0) begin
      last_sw <= sw_q;
      sw_q <= 6'h0;
    end
    if (PORT_TWO_OE === 1'b1) p2_q <= p2_q + 6'h1;
    else if (p2_q != 6'h0) begin
      last_p2 <= p2_q;
      p2_q <= 6'h0;
    end
  end
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checked=%0d n_errors=%0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task axw(input [11:0] ad, input [31:0] d);
    integer n;
    reg b;
    begin
      @(posedge SYS_CLK);
      AWADDR <= ad;
      WDATA <= d;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      b = 1'b0;
      // ready held back one cycle so the response must stand through a stall
      for (n = 0; n < 40 && !b; n = n + 1) begin
        @(posedge SYS_CLK);
        if (AWREADY) AWVALID <= 1'b0;
        if (WREADY) WVALID <= 1'b0;
        if (BVALID === 1'b1 && BREADY) begin
          resp = BRESP;
          BREADY <= 1'b0;
          b = 1'b1;
        end else if (BVALID === 1'b1) BREADY <= 1'b1;
      end
      if (!b) begin
        check(32'h0, 32'h1);
        give_verdict;
      end
    end
  endtask
  task axr(input [11:0] ad, output [31:0] d);
    integer n;
    reg b;
    begin
      @(posedge SYS_CLK);
      ARADDR <= ad;
      ARVALID <= 1'b1;
      b = 1'b0;
      for (n = 0; n < 40 && !b; n = n + 1) begin
        @(posedge SYS_CLK);
        if (ARREADY) ARVALID <= 1'b0;
        if (RVALID === 1'b1 && RREADY) begin
          d = RDATA;
          resp = RRESP;
          RREADY <= 1'b0;
          b = 1'b1;
        end else if (RVALID === 1'b1) RREADY <= 1'b1;
      end
      if (!b) begin
        check(32'h0, 32'h1);
        give_verdict;
      end
    end
  endtask
  // issue a move and poll until idle; leaves status in rd
  task mv(input [31:0] m);
    integer n;
    begin
      axw(`OFF_MOVE, m);
      repeat (4) @(posedge SYS_CLK);
      rd = 32'h1;
      for (n = 0; n < 60 && rd[0] !== 1'b0; n = n + 1) axr(`OFF_STATUS, rd);
      check(rd[0], 1'b0);
      if (rd[0] !== 1'b0) give_verdict;
      repeat (3) @(posedge SYS_CLK);
    end
  endtask
  task t_reset_regs;
    begin
      axr(`OFF_STRETCH, rd);
      check(rd[2:0], 3'h1);
      axr(`OFF_STATUS, rd);
      check(rd[3], EXT_BUS_CFG);
      axr(12'h100, rd);
      check({resp, rd}, {`RESP_SLVERR, 32'h0});
      axw(12'h104, 32'h1);
      check(resp, `RESP_SLVERR);
    end
  endtask
  task t_codes;
    begin
      for (code = 0; code < 8; code = code + 1) begin
        a = {code[7:0] + 8'h12, code[7:0] + 8'h34};
        axw(`OFF_STRETCH, code);
        axr(`OFF_STRETCH, rd);
        check(rd[2:0], code[2:0]);
        axw(`OFF_DPTR0, a);
        mv(32'h0);
        check(last_sw, code == 0 ? 2 : 4 * code);
        check(last_p2, 4 * (code + 2));
        check(rd[15:8], a[7:0] ^ a[15:8]);
      end
    end
  endtask
  task t_pointers;
    begin
      axw(`OFF_DPTR0, 32'h2000);
      axw(`OFF_DPTR1, 32'h3000);
      axw(`OFF_CTRL, 32'h6);
      mv(32'h3a5);
      check(i_ext_mem_model.mem[16'h3000], 8'ha5);
      axr(`OFF_DPTR1, rd);
      check(rd[15:0], 16'h3001);
      axw(`OFF_CTRL, 32'h4);
      mv(32'h0);
      check(rd[15:8], 8'h20);
    end
  endtask
  task t_internal;
    begin
      k = n_ale;
      axw(`OFF_DPTR0, 32'h00ff);
      mv(32'h15a);
      mv(32'h0);
      check({rd[15:8], rd[2]}, {8'h5a, 1'b1});
      check(n_ale, k);
      axw(`OFF_DPTR0, 32'h0100);
      mv(32'h0);
      check({rd[2], n_ale[7:0]}, {1'b0, k[7:0] + 8'h1});
    end
  endtask
  task t_rates;
    begin
      for (f = 0; f < 2; f = f + 1) begin
        axw(`OFF_CTRL, 32'h4 | f);
        axw(`OFF_TIMER, 32'h0);
        axr(`OFF_TIMER, t1);
        repeat (240) @(posedge SYS_CLK);
        axr(`OFF_TIMER, rd);
        k = f ? 60 : 20;
        check(rd[15:0] - t1[15:0] >= k && rd[15:0] - t1[15:0] <= k + 1, 1);
      end
      axr(`OFF_ICOUNT, t1);
      repeat (400) @(posedge SYS_CLK);
      axr(`OFF_ICOUNT, rd);
      check(rd - t1 >= 100 && rd - t1 <= 101, 1);
    end
  endtask
  task t_gpio;
    begin
      @(posedge SYS_CLK);
      RST <= 1'b1;
      EXT_BUS_CFG <= 1'b0;
      repeat (12) @(posedge SYS_CLK);
      RST <= 1'b0;
      @(posedge SYS_CLK);
      t_reset_regs;
      k = n_ale;
      axw(`OFF_DPTR0, 32'h1234);
      mv(32'h0);
      check({rd[1], n_ale[7:0]}, {1'b1, k[7:0]});
      axw(`OFF_GPIO_OUT, 32'h01015a3c);
      repeat (2) @(posedge SYS_CLK);
      check({PORT_TWO_OE, PORT_TWO_O, PORT_ZERO_OE, PORT_ZERO_O}, 18'h2b53c);
      PORT_TWO_I <= 8'h69;
      repeat (3) @(posedge SYS_CLK);
      axr(`OFF_GPIO_IN, rd);
      check(rd[15:8], 8'h69);
    end
  endtask
  initial begin
    repeat (12) @(posedge SYS_CLK);
    RST <= 1'b0;
    @(posedge SYS_CLK);
    t_reset_regs;
    t_codes;
    t_pointers;
    t_internal;
    t_rates;
    t_gpio;
    give_verdict;
  end
endmodule // core_bus_timing_stretch_tb_top
bind core_bus_timing_stretch core_bus_timing_stretch_checker i_chk (.SYS_CLK(SYS_CLK), .RST(RST),
  .EXT_BUS_CFG(EXT_BUS_CFG), .ALE(ALE), .RD_N(RD_N), .WR_N(WR_N), .PORT_ZERO_O(PORT_ZERO_O),
  .PORT_ZERO_OE(PORT_ZERO_OE), .PORT_TWO_OE(PORT_TWO_OE), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
  .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA));
